/* verilog/duart_pkg.sv */
package duart_pkg;

  // bus geometry: one 32-bit word per register, channel picked by an address bit
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned BE_W     = 4;
  localparam int unsigned ADDR_W   = 6;
  localparam int unsigned REG_W    = 8;
  localparam int unsigned CH_BIT   = 5;
  localparam int unsigned IDX_HI   = 4;
  localparam int unsigned IDX_LO   = 2;
  localparam int unsigned IDX_W    = 3;
  localparam int unsigned NUM_CH   = 2;
  localparam int unsigned LANE0    = 0;

  // register index within a channel (byte offset = index * 4, channel b adds 0x20)
  localparam logic [IDX_W-1:0] IDX_ALT     = 3'h0;
  localparam logic [IDX_W-1:0] IDX_IEN     = 3'h1;
  localparam logic [IDX_W-1:0] IDX_IST_FCT = 3'h2;
  localparam logic [IDX_W-1:0] IDX_LCT     = 3'h3;
  localparam logic [IDX_W-1:0] IDX_MCT     = 3'h4;
  localparam logic [IDX_W-1:0] IDX_LST     = 3'h5;
  localparam logic [IDX_W-1:0] IDX_MST     = 3'h6;
  localparam logic [IDX_W-1:0] IDX_SCRATCH = 3'h7;

  // reset values
  localparam logic [REG_W-1:0] IEN_RST     = 8'h00;
  localparam logic [REG_W-1:0] LCT_RST     = 8'h00;
  localparam logic [REG_W-1:0] MCT_RST     = 8'h00;
  localparam logic [REG_W-1:0] FCT_RST     = 8'h00;
  localparam logic [REG_W-1:0] IST_RST     = 8'h01;
  localparam logic [REG_W-1:0] LST_RST     = 8'h60;
  localparam logic [REG_W-1:0] SCRATCH_RST = 8'h00;
  localparam logic [1:0]       FN_SEL_RST  = 2'h0;
  localparam logic             CONC_RST    = 1'b0;
  localparam logic [3:0]       DELTA_RST   = 4'h0;

  // field positions
  localparam int unsigned ALT_CONC_BIT = 0;
  localparam int unsigned ALT_SEL_LO   = 1;
  localparam int unsigned ALT_SEL_HI   = 2;
  localparam int unsigned ALT_UNUSED_W = 5;
  localparam int unsigned MCT_DTR_BIT  = 0;
  localparam int unsigned MCT_RTS_BIT  = 1;
  localparam int unsigned MCT_UO2_BIT  = 3;

  // level driven on the multi-function pin for the reserved code (inactive)
  localparam logic FN_RSVD_LEVEL = 1'b1;

  typedef enum logic [1:0] {
    FN_UO2   = 2'b00,
    FN_BAUD  = 2'b01,
    FN_RXREQ = 2'b10,
    FN_RSVD  = 2'b11
  } duart_fn_sel_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_DONE = 1'b1
  } duart_bus_state_t;

  // per-channel signals coming from the uart datapath and modem pins
  typedef struct packed {
    logic             tx_serial;
    logic             irq_req;
    logic             transmit_dma_request;
    logic             receive_dma_request_n;
    logic             baud_clock_output_n;
    logic             cts_n;
    logic             dsr_n;
    logic             ri_n;
    logic             cd_n;
    logic [REG_W-1:0] line_status;
    logic [REG_W-1:0] interrupt_status;
  } duart_core_in_t;

  // control register values handed to the datapath
  typedef struct packed {
    logic [REG_W-1:0] interrupt_enable_reg;
    logic [REG_W-1:0] line_control_reg;
    logic [REG_W-1:0] modem_control_reg;
    logic [REG_W-1:0] fifo_control_reg;
  } duart_ctrl_t;

  // per-channel output pins at pin level
  typedef struct packed {
    logic serial_transmit_line;
    logic user_output_two_n;
    logic rts_n;
    logic dtr_n;
    logic irq_out;
    logic transmit_dma_request;
    logic multi_function_output_n;
  } duart_pins_t;

endpackage

/* verilog/duart_regs.sv */
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
// Overview of operation
// [R1] - each channel has an 8-bit scratch byte that affects nothing else
// [R2] - alternate function bits 7 to 3 are unused and held at zero
// [R3] - function field picks output-two, baud clock or receive-ready for multi-function pin
// [R4] - with concurrent-write set, one write updates the register in both channels
// [R5] - concurrent-write bit is written through either channel's register set
// [R6] - reads always come from the channel chosen by channel select
// [R7] - host should match both divisor-latch bits before concurrent writes to 0..2
// [R8] - reset clears interrupt enable, line, modem, fifo control and alternate function
// [R9] - after reset interrupt status reads 0x01, no interrupt pending
// [R10] - after reset line status reads with transmitter-empty bits 6 and 5 set
// [R11] - after reset modem status upper bits follow pins, change bits are zero
// [R12] - reset drives transmit, output-two, rts, dtr high and irq, transmit_dma_request low
// [R13] - scratch read returns last value written, with no side effect
module duart_regs (
  input  wire logic                                  clk_sys_i,
  input  wire logic                                  rst_i,
  input  wire logic [duart_pkg::ADDR_W-1:0]          avs_address_i,
  input  wire logic                                  avs_read_i,
  input  wire logic                                  avs_write_i,
  input  wire logic [duart_pkg::DATA_W-1:0]          avs_writedata_i,
  input  wire logic [duart_pkg::BE_W-1:0]            avs_byteenable_i,
  output logic      [duart_pkg::DATA_W-1:0]          avs_readdata_o,
  output logic                                       avs_waitrequest_o,
  input  wire duart_pkg::duart_core_in_t             core_a_i,
  input  wire duart_pkg::duart_core_in_t             core_b_i,
  output duart_pkg::duart_ctrl_t                     ctrl_a_o,
  output duart_pkg::duart_ctrl_t                     ctrl_b_o,
  output duart_pkg::duart_pins_t                     pins_a_o,
  output duart_pkg::duart_pins_t                     pins_b_o
);

  localparam int unsigned W = duart_pkg::REG_W;

  // register state, one entry per channel except the shared concurrent bit
  logic [W-1:0]                   ien_reg     [duart_pkg::NUM_CH];
  logic [W-1:0]                   lct_reg     [duart_pkg::NUM_CH];
  logic [W-1:0]                   mct_reg     [duart_pkg::NUM_CH];
  logic [W-1:0]                   fct_reg     [duart_pkg::NUM_CH];
  logic [W-1:0]                   ist_reg     [duart_pkg::NUM_CH];
  logic [W-1:0]                   lst_reg     [duart_pkg::NUM_CH];
  logic [W-1:0]                   scratch_reg [duart_pkg::NUM_CH];
  logic [1:0]                     fn_sel_reg  [duart_pkg::NUM_CH];
  logic [3:0]                     modem_reg   [duart_pkg::NUM_CH];
  logic [3:0]                     modem_prev_reg [duart_pkg::NUM_CH];
  logic [3:0]                     delta_reg   [duart_pkg::NUM_CH];
  logic [3:0]                     delta_next  [duart_pkg::NUM_CH];
  logic                           conc_reg;
  duart_pkg::duart_core_in_t      core_in     [duart_pkg::NUM_CH];
  duart_pkg::duart_pins_t         pins_reg    [duart_pkg::NUM_CH];
  duart_pkg::duart_pins_t         pins_next   [duart_pkg::NUM_CH];

  // bus side
  duart_pkg::duart_bus_state_t    state_reg;
  duart_pkg::duart_bus_state_t    state_next;
  logic [duart_pkg::DATA_W-1:0]   readdata_reg;
  logic                           bus_req;
  logic                           wr_fire;
  logic                           rd_fire;
  logic                           sel_ch;
  logic [duart_pkg::IDX_W-1:0]    sel_idx;
  logic [W-1:0]                   wr_byte;
  logic [W-1:0]                   rd_byte;

  // does a write accepted now land in channel ch
  function automatic logic chan_written(input logic ch, input logic sel, input logic conc);
    chan_written = (ch == sel) || conc;
  endfunction

  // modem pins gathered in status-bit order: cd, ri, dsr, cts
  function automatic logic [3:0] modem_pins(input duart_pkg::duart_core_in_t c);
    modem_pins = {c.cd_n, c.ri_n, c.dsr_n, c.cts_n};
  endfunction

  // read multiplexer over one channel's registers
  function automatic logic [W-1:0] reg_read(
    input logic [duart_pkg::IDX_W-1:0] idx,
    input logic [W-1:0]                ien,
    input logic [W-1:0]                ist,
    input logic [W-1:0]                lct,
    input logic [W-1:0]                mct,
    input logic [W-1:0]                lst,
    input logic [3:0]                  modem,
    input logic [3:0]                  delta,
    input logic [W-1:0]                scratch,
    input logic [1:0]                  fn_sel,
    input logic                        conc
  );
    logic [W-1:0] v;
    v = '0;
    if (idx == duart_pkg::IDX_ALT) begin
      v = {{duart_pkg::ALT_UNUSED_W{1'b0}}, fn_sel, conc}; // [R2]
    end else if (idx == duart_pkg::IDX_IEN) begin
      v = ien;
    end else if (idx == duart_pkg::IDX_IST_FCT) begin
      v = ist;
    end else if (idx == duart_pkg::IDX_LCT) begin
      v = lct;
    end else if (idx == duart_pkg::IDX_MCT) begin
      v = mct;
    end else if (idx == duart_pkg::IDX_LST) begin
      v = lst;
    end else if (idx == duart_pkg::IDX_MST) begin
      v = {modem, delta};
    end else begin
      v = scratch; // [R13]
    end
    reg_read = v;
  endfunction

  assign core_in[0] = core_a_i;
  assign core_in[1] = core_b_i;

  // address decode; the channel bit acts as channel select
  assign sel_ch  = avs_address_i[duart_pkg::CH_BIT];
  assign sel_idx = avs_address_i[duart_pkg::IDX_HI:duart_pkg::IDX_LO];
  assign wr_byte = avs_writedata_i[W-1:0];
  assign bus_req = avs_read_i || avs_write_i;

  // every access takes one wait cycle, then completes at the next edge
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      duart_pkg::BUS_IDLE: begin
        if (bus_req) begin
          state_next = duart_pkg::BUS_DONE;
        end
      end
      duart_pkg::BUS_DONE: begin
        state_next = duart_pkg::BUS_IDLE;
      end
      default: begin
        state_next = duart_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg <= duart_pkg::BUS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign avs_waitrequest_o = bus_req && (state_reg == duart_pkg::BUS_IDLE);
  // only lane 0 carries register data; other lanes are ignored on write
  assign wr_fire = avs_write_i && (state_reg == duart_pkg::BUS_DONE) && avs_byteenable_i[duart_pkg::LANE0];
  assign rd_fire = avs_read_i && (state_reg == duart_pkg::BUS_DONE);

  // read data selected by channel select only, never by the concurrent bit
  always_comb begin
    if (sel_ch) begin
      rd_byte = reg_read(sel_idx, ien_reg[1], ist_reg[1], lct_reg[1], mct_reg[1], lst_reg[1],
                         modem_reg[1], delta_reg[1], scratch_reg[1], fn_sel_reg[1], conc_reg); // [R6]
    end else begin
      rd_byte = reg_read(sel_idx, ien_reg[0], ist_reg[0], lct_reg[0], mct_reg[0], lst_reg[0],
                         modem_reg[0], delta_reg[0], scratch_reg[0], fn_sel_reg[0], conc_reg); // [R6]
    end
  end

  // captured in the wait cycle so it stands at the completing edge
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      readdata_reg <= '0;
    end else if (avs_read_i && (state_reg == duart_pkg::BUS_IDLE)) begin
      readdata_reg <= {{(duart_pkg::DATA_W - W){1'b0}}, rd_byte};
    end
  end

  assign avs_readdata_o = readdata_reg;

  // concurrent-write bit is shared; a write to either set's function register moves it
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      conc_reg <= duart_pkg::CONC_RST; // [R8]
    end else if (wr_fire && (sel_idx == duart_pkg::IDX_ALT)) begin
      conc_reg <= wr_byte[duart_pkg::ALT_CONC_BIT]; // [R5]
    end
  end

  // host-written control registers; the concurrent bit fans the write out to both channels
  always_ff @(posedge clk_sys_i) begin
    for (int ch = 0; ch < duart_pkg::NUM_CH; ch++) begin
      if (rst_i) begin
        ien_reg[ch]    <= duart_pkg::IEN_RST; // [R8]
        lct_reg[ch]    <= duart_pkg::LCT_RST; // [R8]
        mct_reg[ch]    <= duart_pkg::MCT_RST; // [R8]
        fct_reg[ch]    <= duart_pkg::FCT_RST; // [R8]
        fn_sel_reg[ch] <= duart_pkg::FN_SEL_RST; // [R8]
      end else if (wr_fire && chan_written(ch[0], sel_ch, conc_reg)) begin // [R4]
        if (sel_idx == duart_pkg::IDX_IEN) begin
          ien_reg[ch] <= wr_byte;
        end else if (sel_idx == duart_pkg::IDX_IST_FCT) begin
          fct_reg[ch] <= wr_byte;
        end else if (sel_idx == duart_pkg::IDX_LCT) begin
          lct_reg[ch] <= wr_byte; // divisor-latch bits are the host's to keep aligned [R7]
        end else if (sel_idx == duart_pkg::IDX_MCT) begin
          mct_reg[ch] <= wr_byte;
        end else if (sel_idx == duart_pkg::IDX_ALT) begin
          fn_sel_reg[ch] <= wr_byte[duart_pkg::ALT_SEL_HI:duart_pkg::ALT_SEL_LO]; // upper bits dropped [R2]
        end
      end
    end
  end

  // scratch byte is plain storage with no reset requirement; cleared for determinism
  always_ff @(posedge clk_sys_i) begin
    for (int ch = 0; ch < duart_pkg::NUM_CH; ch++) begin
      if (rst_i) begin
        scratch_reg[ch] <= duart_pkg::SCRATCH_RST;
      end else if (wr_fire && chan_written(ch[0], sel_ch, conc_reg) && (sel_idx == duart_pkg::IDX_SCRATCH)) begin
        scratch_reg[ch] <= wr_byte; // [R1]
      end
    end
  end

  // interrupt and line status mirror the datapath, forced to idle values in reset
  always_ff @(posedge clk_sys_i) begin
    for (int ch = 0; ch < duart_pkg::NUM_CH; ch++) begin
      if (rst_i) begin
        ist_reg[ch] <= duart_pkg::IST_RST; // [R9]
        lst_reg[ch] <= duart_pkg::LST_RST; // [R10]
      end else begin
        ist_reg[ch] <= core_in[ch].interrupt_status;
        lst_reg[ch] <= core_in[ch].line_status;
      end
    end
  end

  // change flags: set on a pin change, cleared by a modem status read; set wins
  always_comb begin
    for (int ch = 0; ch < duart_pkg::NUM_CH; ch++) begin
      logic [3:0] cur;
      logic [3:0] chg;
      logic       clr;
      cur = modem_pins(core_in[ch]);
      chg = cur ^ modem_prev_reg[ch];
      chg[2] = cur[2] && !modem_prev_reg[ch][2]; // ring flag only on the trailing edge of ring
      clr = rd_fire && (sel_idx == duart_pkg::IDX_MST) && (sel_ch == ch[0]);
      delta_next[ch] = (clr ? duart_pkg::DELTA_RST : delta_reg[ch]) | chg;
    end
  end

  // status bits are complements of the active-low pins, tracked even through reset
  always_ff @(posedge clk_sys_i) begin
    for (int ch = 0; ch < duart_pkg::NUM_CH; ch++) begin
      modem_reg[ch]      <= ~modem_pins(core_in[ch]); // [R11]
      modem_prev_reg[ch] <= modem_pins(core_in[ch]);
      if (rst_i) begin
        delta_reg[ch] <= duart_pkg::DELTA_RST; // [R11]
      end else begin
        delta_reg[ch] <= delta_next[ch];
      end
    end
  end

  // next pin levels; multi-function pin follows the per-channel selector
  always_comb begin
    for (int ch = 0; ch < duart_pkg::NUM_CH; ch++) begin
      pins_next[ch].serial_transmit_line = core_in[ch].tx_serial;
      pins_next[ch].user_output_two_n    = ~mct_reg[ch][duart_pkg::MCT_UO2_BIT];
      pins_next[ch].rts_n                = ~mct_reg[ch][duart_pkg::MCT_RTS_BIT];
      pins_next[ch].dtr_n                = ~mct_reg[ch][duart_pkg::MCT_DTR_BIT];
      pins_next[ch].irq_out              = core_in[ch].irq_req;
      pins_next[ch].transmit_dma_request = core_in[ch].transmit_dma_request;
      case (duart_pkg::duart_fn_sel_t'(fn_sel_reg[ch]))
        duart_pkg::FN_UO2: begin
          pins_next[ch].multi_function_output_n = ~mct_reg[ch][duart_pkg::MCT_UO2_BIT]; // [R3]
        end
        duart_pkg::FN_BAUD: begin
          pins_next[ch].multi_function_output_n = core_in[ch].baud_clock_output_n; // [R3]
        end
        duart_pkg::FN_RXREQ: begin
          pins_next[ch].multi_function_output_n = core_in[ch].receive_dma_request_n; // [R3]
        end
        default: begin
          pins_next[ch].multi_function_output_n = duart_pkg::FN_RSVD_LEVEL; // [R3]
        end
      endcase
    end
  end

  // pins are registered: adds one cycle of latency but keeps the reset levels glitch free
  always_ff @(posedge clk_sys_i) begin
    for (int ch = 0; ch < duart_pkg::NUM_CH; ch++) begin
      if (rst_i) begin
        pins_reg[ch].serial_transmit_line    <= 1'b1; // [R12]
        pins_reg[ch].user_output_two_n       <= 1'b1; // [R12]
        pins_reg[ch].rts_n                   <= 1'b1; // [R12]
        pins_reg[ch].dtr_n                   <= 1'b1; // [R12]
        pins_reg[ch].irq_out                 <= 1'b0; // [R12]
        pins_reg[ch].transmit_dma_request    <= 1'b0; // [R12]
        pins_reg[ch].multi_function_output_n <= 1'b1;
      end else begin
        pins_reg[ch] <= pins_next[ch];
      end
    end
  end

  assign pins_a_o = pins_reg[0];
  assign pins_b_o = pins_reg[1];

  // control values for the datapath
  assign ctrl_a_o = '{ien_reg[0], lct_reg[0], mct_reg[0], fct_reg[0]};
  assign ctrl_b_o = '{ien_reg[1], lct_reg[1], mct_reg[1], fct_reg[1]};

endmodule

/* verification/duart_regs_props.sv */
`timescale 1ns/10ps
module duart_regs_props (
  input wire logic                            clk_sys_i,
  input wire logic                            rst_i,
  input wire logic [duart_pkg::ADDR_W-1:0]    avs_address_i,
  input wire logic                            avs_read_i,
  input wire logic                            avs_write_i,
  input wire logic [duart_pkg::DATA_W-1:0]    avs_writedata_i,
  input wire logic [duart_pkg::BE_W-1:0]      avs_byteenable_i,
  input wire logic [duart_pkg::DATA_W-1:0]    avs_readdata_o,
  input wire logic                            avs_waitrequest_o,
  input wire duart_pkg::duart_core_in_t       core_a_i,
  input wire duart_pkg::duart_core_in_t       core_b_i,
  input wire duart_pkg::duart_ctrl_t          ctrl_a_o,
  input wire duart_pkg::duart_ctrl_t          ctrl_b_o,
  input wire duart_pkg::duart_pins_t          pins_a_o,
  input wire duart_pkg::duart_pins_t          pins_b_o
);
  logic       wr_ok, rd_ok, ch, conc_q, fo_a, fo_b;
  logic [2:0] idx;
  logic [1:0] sel_a_q, sel_b_q;
  logic [7:0] scr_q [2];

  // completed transfers, decoded the way the host sees them
  assign idx   = avs_address_i[duart_pkg::IDX_HI:duart_pkg::IDX_LO];
  assign ch    = avs_address_i[duart_pkg::CH_BIT];
  assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  assign rd_ok = avs_read_i && !avs_waitrequest_o;

  // shadow of the registers the ports cannot show
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      conc_q   <= 1'b0;
      sel_a_q  <= 2'h0;
      sel_b_q  <= 2'h0;
      scr_q[0] <= 8'h00;
      scr_q[1] <= 8'h00;
    end else if (wr_ok && idx == 3'h0) begin
      conc_q <= avs_writedata_i[0];
      if (conc_q || !ch) sel_a_q <= avs_writedata_i[2:1];
      if (conc_q || ch) sel_b_q <= avs_writedata_i[2:1];
    end else if (wr_ok && idx == 3'h7) begin
      if (conc_q || !ch) scr_q[0] <= avs_writedata_i[7:0];
      if (conc_q || ch) scr_q[1] <= avs_writedata_i[7:0];
    end
  end

  // expected pin level; reserved code parks the pin inactive
  function automatic logic fo_f(input logic [1:0] s, input logic uo2, input logic bd, input logic rx);
    return (s == 2'h0) ? ~uo2 : (s == 2'h1) ? bd : (s == 2'h2) ? rx : 1'b1;
  endfunction
  assign fo_a = fo_f(sel_a_q, ctrl_a_o.modem_control_reg[3], core_a_i.baud_clock_output_n,
                     core_a_i.receive_dma_request_n);
  assign fo_b = fo_f(sel_b_q, ctrl_b_o.modem_control_reg[3], core_b_i.baud_clock_output_n,
                     core_b_i.receive_dma_request_n);

  property p_rst_pins;
    @(posedge clk_sys_i) rst_i |=> {pins_a_o[6:1], pins_b_o[6:1]} == 12'hf3c;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("reset pin levels wrong");
  property p_rst_ctrl;
    @(posedge clk_sys_i) rst_i |=> ctrl_a_o == '0 && ctrl_b_o == '0;
  endproperty
  a_rst_ctrl: assert property (p_rst_ctrl) else $error("control registers not cleared");
  property p_alt_rd;
    @(posedge clk_sys_i) disable iff (rst_i) rd_ok && idx == 3'h0 |-> avs_readdata_o[7:3] == 5'h00;
  endproperty
  a_alt_rd: assert property (p_alt_rd) else $error("unused function bits set");
  property p_fo_a;
    @(posedge clk_sys_i) disable iff (rst_i) 1'b1 |=> pins_a_o.multi_function_output_n == $past(fo_a);
  endproperty
  a_fo_a: assert property (p_fo_a) else $error("channel a function pin wrong");
  property p_fo_b;
    @(posedge clk_sys_i) disable iff (rst_i) 1'b1 |=> pins_b_o.multi_function_output_n == $past(fo_b);
  endproperty
  a_fo_b: assert property (p_fo_b) else $error("channel b function pin wrong");
  property p_conc_wr;
    @(posedge clk_sys_i) disable iff (rst_i) wr_ok && conc_q && idx == 3'h1 |=>
      ctrl_a_o.interrupt_enable_reg == $past(avs_writedata_i[7:0]) &&
      ctrl_b_o.interrupt_enable_reg == $past(avs_writedata_i[7:0]);
  endproperty
  a_conc_wr: assert property (p_conc_wr) else $error("concurrent write missed a channel");
  property p_single_wr;
    @(posedge clk_sys_i) disable iff (rst_i) wr_ok && !conc_q && idx == 3'h1 && !ch |=>
      $stable(ctrl_b_o.interrupt_enable_reg);
  endproperty
  a_single_wr: assert property (p_single_wr) else $error("single write leaked to channel b");
  property p_rd_sel;
    @(posedge clk_sys_i) disable iff (rst_i) rd_ok && idx == 3'h3 |->
      avs_readdata_o[7:0] == (ch ? ctrl_b_o.line_control_reg : ctrl_a_o.line_control_reg);
  endproperty
  a_rd_sel: assert property (p_rd_sel) else $error("read from wrong channel");
  property p_scr;
    @(posedge clk_sys_i) disable iff (rst_i) rd_ok && idx == 3'h7 |-> avs_readdata_o[7:0] == scr_q[ch];
  endproperty
  a_scr: assert property (p_scr) else $error("scratch readback wrong");
  property p_conc_rd;
    @(posedge clk_sys_i) disable iff (rst_i) rd_ok && idx == 3'h0 |-> avs_readdata_o[0] == conc_q;
  endproperty
  a_conc_rd: assert property (p_conc_rd) else $error("concurrent bit readback wrong");
endmodule

bind duart_regs duart_regs_props u_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .core_a_i(core_a_i), .core_b_i(core_b_i), .ctrl_a_o(ctrl_a_o), .ctrl_b_o(ctrl_b_o), .pins_a_o(pins_a_o),
  .pins_b_o(pins_b_o));

/* verification/duart_core_model.sv */
`timescale 1ns/10ps
module duart_core_model (
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_i,
  input  wire logic [3:0]               modem_n_i,
  input  wire logic                     rxreq_n_i,
  output duart_pkg::duart_core_in_t     core_a_o,
  output duart_pkg::duart_core_in_t     core_b_o
);
  logic baud_n_reg;

  // stand-in baud divider, fastest possible so any sampling slip shows
  always_ff @(posedge clk_sys_i) begin
    if (rst_i)
      baud_n_reg <= 1'b1;
    else
      baud_n_reg <= ~baud_n_reg;
  end

  // idle channels; during reset the core lines sit at the wrong level on purpose
  always_comb begin
    core_a_o = '0;
    core_a_o.tx_serial = ~rst_i;
    core_a_o.irq_req = rst_i;
    core_a_o.transmit_dma_request = rst_i;
    core_a_o.baud_clock_output_n = baud_n_reg;
    core_a_o.receive_dma_request_n = rxreq_n_i;
    {core_a_o.cd_n, core_a_o.ri_n, core_a_o.dsr_n, core_a_o.cts_n} = modem_n_i;
    core_a_o.line_status = 8'h60;
    core_a_o.interrupt_status = 8'h01;
    core_b_o = core_a_o;
    core_b_o.receive_dma_request_n = ~rxreq_n_i;
  end
endmodule

/* verification/testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic                        clk_sys_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, rxreq_n;
  logic [5:0]                  avs_address_i;
  logic [31:0]                 avs_writedata_i, avs_readdata_o;
  logic [3:0]                  avs_byteenable_i, modem_n;
  logic [7:0]                  q, p0, p1;
  int                          err_total, checks_done, cyc;
  duart_pkg::duart_core_in_t   core_a, core_b;
  duart_pkg::duart_ctrl_t      ctrl_a, ctrl_b;
  duart_pkg::duart_pins_t      pins_a, pins_b;

  duart_core_model u_core (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .modem_n_i(modem_n), .rxreq_n_i(rxreq_n),
    .core_a_o(core_a), .core_b_o(core_b));
  duart_regs u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .core_a_i(core_a), .core_b_i(core_b),
    .ctrl_a_o(ctrl_a), .ctrl_b_o(ctrl_b), .pins_a_o(pins_a), .pins_b_o(pins_b));

  // clock, 25 ns period
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // hang guard, the whole sequence needs well under a thousand cycles
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one bus cycle; waitrequest and read data taken at the rising edge, released right after it
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_byteenable_i <= be;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask
  task automatic rd_chk(input string nm, input logic [5:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 4'h0);
    chk(nm, q, exp);
  endtask

  // every register except scratch of both channels read straight after reset
  task automatic t_reset;
    logic [5:0] ra [7];
    logic [7:0] re [7];
    ra = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18};
    re = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'h90};
    chk("fifo ctrl", {ctrl_a.fifo_control_reg | ctrl_b.fifo_control_reg}, 8'h00);
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < 7; i++) begin
        rd_chk("reset value", ra[i] | 6'(c * 32), re[i]);
      end
    end
  endtask

  // scratch bytes per channel, masked write ignored, nothing else disturbed
  task automatic t_scratch;
    wr(6'h1c, 8'h5a);
    wr(6'h3c, 8'ha5);
    bus(1'b1, 6'h1c, 8'hff, 4'he);
    rd_chk("scratch a", 6'h1c, 8'h5a);
    rd_chk("scratch b", 6'h3c, 8'ha5);
    rd_chk("lct a", 6'h0c, 8'h00);
    rd_chk("ist a", 6'h08, 8'h01);
  endtask

  // concurrent write set through a, cleared through b
  task automatic t_conc;
    wr(6'h00, 8'h01);
    rd_chk("conc via b", 6'h20, 8'h01);
    wr(6'h24, 8'h0f); // both line controls still zero here
    rd_chk("ien a conc", 6'h04, 8'h0f);
    rd_chk("ien b conc", 6'h24, 8'h0f);
    rd_chk("scratch a conc", 6'h1c, 8'h5a);
    rd_chk("scratch b conc", 6'h3c, 8'ha5);
    wr(6'h20, 8'h00);
    rd_chk("conc cleared", 6'h00, 8'h00);
    wr(6'h04, 8'h33);
    rd_chk("ien a single", 6'h04, 8'h33);
    rd_chk("ien b single", 6'h24, 8'h0f);
  endtask

  // every function code on channel a's pin, baud code must toggle
  task automatic t_mf;
    logic [7:0] ex [4];
    ex = '{8'h00, 8'h00, 8'h00, 8'h01};
    wr(6'h10, 8'h08);
    for (int c = 0; c < 4; c++) begin
      wr(6'h00, 8'(c * 2));
      repeat (2) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      p0 = {7'h0, pins_a.multi_function_output_n};
      @(negedge clk_sys_i);
      p1 = {7'h0, pins_a.multi_function_output_n};
      if (c == 1)
        chk("baud toggle", p1, p0 ^ 8'h01);
      else
        chk("fn pin", p0 | p1 << 1, ex[c] | ex[c] << 1);
    end
    chk("uo2 pin", {7'h0, pins_a.user_output_two_n}, 8'h00);
    chk("fn pin b", {7'h0, pins_b.multi_function_output_n}, 8'h01);
  endtask

  // main sequence
  initial begin
    err_total = 0;
    checks_done = 0;
    cyc = 0;
    rst_i = 1'b1;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 6'h00;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'h0;
    modem_n = 4'h6;
    rxreq_n = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    chk("reset pins", {2'h0, pins_a[6:1]}, 8'h3c);
    chk("reset pins b", {2'h0, pins_b[6:1]}, 8'h3c);
    rst_i <= 1'b0;
    t_reset();
    t_scratch();
    t_conc();
    t_mf();
    conclude();
  end
endmodule
